// [mci_capture.sv]
// four-channel capture front end: select, detect, crop, scale, buffer
`default_nettype none
`include "mci_regs.svh"
// Summary of operation
// RULE1 - four independent paths, each with source selector
// RULE2 - select 0-3 decoder, 4-7 demuxed channels
// RULE3 - demuxed source keeps only its channel id
// RULE4 - order: select, detect, crop, scale, buffer
// RULE5 - watchdog sets no-signal flag on timeout
// RULE6 - report wide, pal and ntsc format flags
// RULE7 - per-channel crop origin at C3 to C6
// RULE8 - shared crop length at A4 and A5
// RULE9 - software keeps span multiple of 4/2
// RULE10 - partition mode at A0, values 0-5,8
// RULE11 - modes 0,1 scaling per channel
// RULE12 - modes 2,3 scaling per channel
// RULE13 - modes 4,5,8 scaling per channel
// RULE14 - low-pass before horizontal subsampling
// RULE15 - vertical scaling drops lines, top field
// RULE16 - channel id in low nibble of byte 3
// RULE17 - no-signal path still emits timed output; path emits nothing while vblank_ff is set, as after reset with no video

// ****************************************
// small fifo, width and depth parameters
// ****************************************
module mci_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clock,
  input  wire logic             i_resetn,
  input  wire logic             i_enable,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  output logic      [WIDTH-1:0] o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ff;
  logic [AW:0]      rd_ff;
  logic             push;
  logic             pop;
  assign o_ready = (wr_ff - rd_ff) != (AW+1)'(DEPTH); // full when pointers differ by depth
  assign o_valid = wr_ff != rd_ff;
  assign push    = i_enable && i_valid && o_ready;
  assign pop     = i_enable && o_valid && i_ready;
  assign o_data  = mem[rd_ff[AW-1:0]];
  // pointers carry one extra bit to tell full from empty
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ff <= wr_ff + 1'b1;
      if (pop)
        rd_ff <= rd_ff + 1'b1;
    end
  end
  // storage has no reset
  always_ff @(posedge i_clock)
  begin
    if (push)
      mem[wr_ff[AW-1:0]] <= i_data;
  end
endmodule

// ****************************************
// one capture path
// ****************************************
module mci_path
  import mci_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_enable,
  input  wire logic [71:0] i_streams,
  input  wire logic [2:0]  i_select,
  input  wire logic [7:0]  i_origin,
  input  wire logic [15:0] i_span,
  input  wire mci_hscale_t i_hscale,
  input  wire logic        i_vhalf,
  output mci_status_t      o_status,
  output logic [7:0]       o_data,
  output logic             o_valid,
  input  wire logic        i_ready
);
  logic [7:0]  src;
  logic [7:0]  b1_ff, b2_ff, b3_ff;
  logic        trs;
  logic        field_ff;
  logic        vblank_ff;
  logic [11:0] hpos_ff;
  logic [11:0] hlen_ff;
  logic [9:0]  lines_ff;
  logic [9:0]  flines_ff;
  logic [31:0] dog_ff;
  logic        nosig_ff;
  logic        vkeep_ff;
  logic [7:0]  prev_ff;
  logic [1:0]  phase_ff;
  logic        in_win;
  logic        keep;
  logic [8:0]  filt;
  logic [7:0]  fdata_ff;
  logic        fvalid_ff;
  logic        f_ready;
  logic [11:0] start;

  // channel switch picks one of eight eight-bit buses
  assign src = i_streams[i_select*8 +: 8]; // RULE1 RULE2
  assign trs = (b3_ff == 8'hFF) && (b2_ff == 8'h00) && (b1_ff == 8'h00) && src[7];
  // crop window counted in samples after the start-of-active code
  assign start = {3'b000, i_origin, 1'b0};
  assign in_win = !vblank_ff && (hpos_ff >= start) && (hpos_ff < start + i_span[11:0]); // RULE7 RULE8
  // two-tap average as decimation low-pass; unity scale bypasses it
  assign filt = {1'b0, src} + {1'b0, prev_ff}; // RULE14
  always_comb
  begin
    case (i_hscale)
      MCI_SCALE_FULL:    keep = 1'b1;
      MCI_SCALE_HALF:    keep = (phase_ff[0] == 1'b1);
      MCI_SCALE_QUARTER: keep = (phase_ff == 2'b11);
      default:           keep = 1'b0;
    endcase
  end

  // byte history for timing reference search
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      b1_ff <= 8'h00;
      b2_ff <= 8'h00;
      b3_ff <= 8'h00;
      prev_ff <= 8'h00;
    end
    else if (i_enable)
    begin
      b3_ff <= b2_ff;
      b2_ff <= b1_ff;
      b1_ff <= src;
      prev_ff <= src;
    end
  end

  // line and field tracking from the fourth code byte
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      field_ff <= 1'b0;
      vblank_ff <= 1'b1;
      hpos_ff <= '0;
      hlen_ff <= '0;
      lines_ff <= '0;
      flines_ff <= '0;
      vkeep_ff <= 1'b1;
    end
    else if (i_enable)
    begin
      hpos_ff <= hpos_ff + 1'b1;
      if (trs && !src[4])
      begin
        hpos_ff <= '0;
        field_ff <= src[6];
        vblank_ff <= src[5];
        if (field_ff != src[6])
        begin
          flines_ff <= lines_ff;
          lines_ff <= '0;
          vkeep_ff <= 1'b1;
        end
        else
        begin
          lines_ff <= lines_ff + 1'b1;
          vkeep_ff <= !vkeep_ff;
        end
      end
      else if (trs && src[4])
        hlen_ff <= hpos_ff; // active length up to end-of-active
    end
  end

  // watchdog: flag drops at the first field change after it was set, even if that field was partial
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      dog_ff <= '0;
      nosig_ff <= 1'b1;
    end
    else if (i_enable)
    begin
      if (trs && !src[4] && (field_ff != src[6]))
      begin
        dog_ff <= '0;
        nosig_ff <= 1'b0; // RULE5
      end
      else if (dog_ff >= 32'(`MCI_TIMEOUT_CYCLES))
      begin
        dog_ff <= '0;
        nosig_ff <= 1'b1; // RULE5
      end
      else
        dog_ff <= dog_ff + 1'b1;
    end
  end

  // format flags follow measured line width and field depth
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      o_status <= '{1'b1, 1'b0, 1'b0, 1'b0};
    else if (i_enable)
    begin
      o_status.no_signal_flag   <= nosig_ff;
      o_status.wide_source_flag <= !nosig_ff && (hlen_ff >= `MCI_WIDE_SAMPLES - 12'd4); // RULE6
      o_status.pal_lines_flag   <= !nosig_ff && (flines_ff >= `MCI_PAL_LINES); // RULE6
      o_status.ntsc_lines_flag  <= !nosig_ff && (flines_ff >= `MCI_NTSC_LINES)
                                   && (flines_ff < `MCI_PAL_LINES); // RULE6
    end
  end

  // crop, filter, subsample and drop lines; samples are lost while buffer full
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      phase_ff <= 2'b00;
      fdata_ff <= 8'h00;
      fvalid_ff <= 1'b0;
    end
    else if (i_enable)
    begin
      fvalid_ff <= 1'b0;
      // phase restarts on the code itself so a window at sample 0 is aligned
      if (trs && !src[4])
        phase_ff <= 2'b00;
      else if (in_win)
        phase_ff <= phase_ff + 1'b1;
      // timing runs on without video so the mixer can fill a colour
      if (in_win && keep && (!i_vhalf || (vkeep_ff && !field_ff)) && f_ready) // RULE4 RULE15 RULE17
      begin
        fvalid_ff <= 1'b1;
        fdata_ff <= nosig_ff ? 8'h10 : (i_hscale == MCI_SCALE_FULL) ? src : filt[8:1]; // RULE14 RULE17
      end
    end
  end

  // eight-entry buffer toward the mixer core
  mci_fifo #(.WIDTH(8), .DEPTH(`MCI_FIFO_DEPTH)) u_fifo (
    .i_clock (i_clock),
    .i_resetn(i_resetn),
    .i_enable(i_enable),
    .i_data  (fdata_ff),
    .i_valid (fvalid_ff),
    .o_ready (f_ready),
    .o_data  (o_data),
    .o_valid (o_valid),
    .i_ready (i_ready)
  );
endmodule

// ****************************************
// top: registers, demux, four paths
// ****************************************
module mci_capture
  import mci_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_enable,
  input  wire logic [31:0] i_decoder_stream,
  input  wire logic [7:0]  i_tdm_stream,
  input  wire logic        i_reg_write,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic [7:0]       o_reg_rdata,
  output logic [31:0]      o_path_data,
  output logic [3:0]       o_path_valid,
  input  wire logic [3:0]  i_path_ready,
  output logic [15:0]      o_path_status
);
  logic [7:0]  mode_ff;
  logic [15:0] span_ff;
  logic [7:0]  origin_ff [4];
  logic [11:0] select_ff;
  logic [7:0]  tdm_s1_ff, tdm_s2_ff;
  logic [7:0]  t1_ff, t2_ff, t3_ff;
  logic [1:0]  chan_ff;
  logic [1:0]  cur_chan;
  logic        tdm_trs;
  logic [31:0] demuxed_input_stream;
  logic [71:0] streams;
  mci_hscale_t hs [4];
  logic [3:0]  vh;
  mci_status_t st [4];

  // pin bus crosses in through two flops
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      tdm_s1_ff <= 8'h00;
      tdm_s2_ff <= 8'h00;
      t1_ff <= 8'h00;
      t2_ff <= 8'h00;
      t3_ff <= 8'h00;
      chan_ff <= 2'b00;
    end
    else if (i_enable)
    begin
      tdm_s1_ff <= i_tdm_stream;
      tdm_s2_ff <= tdm_s1_ff;
      t3_ff <= t2_ff;
      t2_ff <= t1_ff;
      t1_ff <= tdm_s2_ff;
      if (tdm_trs)
        chan_ff <= tdm_s2_ff[1:0]; // RULE16
    end
  end

  // bytes leave three places late, so a code's preamble reaches the channel its last byte names
  assign tdm_trs  = (t3_ff == 8'hFF) && (t2_ff == 8'h00) && (t1_ff == 8'h00) && tdm_s2_ff[7];
  assign cur_chan = tdm_trs ? tdm_s2_ff[1:0] : chan_ff; // RULE16
  always_comb
  begin
    for (int c = 0; c < 4; c++)
      demuxed_input_stream[c*8 +: 8] = (cur_chan == 2'(c)) ? t3_ff : 8'h00; // RULE3
  end
  assign streams = {8'h00, demuxed_input_stream, i_decoder_stream};

  // register writes, origin block is contiguous
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      mode_ff <= `MCI_RST_PART_MODE;
      span_ff <= `MCI_RST_SPAN;
      select_ff <= `MCI_RST_SELECT; // paths 0..3 default to decoders 0..3
      for (int c = 0; c < 4; c++)
        origin_ff[c] <= `MCI_RST_ORIGIN;
    end
    else if (i_enable && i_reg_write)
    begin
      case (i_reg_addr)
        `MCI_OFF_PART_MODE: mode_ff <= i_reg_wdata; // RULE10
        `MCI_OFF_SPAN_LO:   span_ff[7:0] <= i_reg_wdata; // RULE8
        `MCI_OFF_SPAN_HI:   span_ff[15:8] <= i_reg_wdata; // RULE8
        `MCI_OFF_SOURCE_SEL:     select_ff[5:0] <= i_reg_wdata[5:0]; // RULE2
        `MCI_OFF_SOURCE_SEL + 8'h01: select_ff[11:6] <= i_reg_wdata[5:0]; // RULE2
        default:
          if (i_reg_addr >= `MCI_OFF_ORIGIN_CH0 && i_reg_addr <= `MCI_OFF_ORIGIN_CH3)
            origin_ff[2'(i_reg_addr - `MCI_OFF_ORIGIN_CH0)] <= i_reg_wdata; // RULE7
      endcase
    end
  end

  // readback; status of path n sits at status base plus n
  always_comb
  begin
    o_reg_rdata = 8'h00;
    case (i_reg_addr)
      `MCI_OFF_PART_MODE:  o_reg_rdata = mode_ff;
      `MCI_OFF_SPAN_LO:    o_reg_rdata = span_ff[7:0];
      `MCI_OFF_SPAN_HI:    o_reg_rdata = span_ff[15:8];
      `MCI_OFF_SOURCE_SEL: o_reg_rdata = {2'b00, select_ff[5:0]};
      `MCI_OFF_SOURCE_SEL + 8'h01: o_reg_rdata = {2'b00, select_ff[11:6]};
      default:
        if (i_reg_addr >= `MCI_OFF_ORIGIN_CH0 && i_reg_addr <= `MCI_OFF_ORIGIN_CH3)
          o_reg_rdata = origin_ff[2'(i_reg_addr - `MCI_OFF_ORIGIN_CH0)];
        else if (i_reg_addr >= `MCI_OFF_STATUS_BASE && i_reg_addr < `MCI_OFF_STATUS_BASE + 8'h04)
          o_reg_rdata = {4'h0, st[2'(i_reg_addr - `MCI_OFF_STATUS_BASE)]};
    endcase
  end

  // scaling table; unused channel and invalid mode are switched off
  always_comb
  begin
    hs = '{MCI_SCALE_OFF, MCI_SCALE_OFF, MCI_SCALE_OFF, MCI_SCALE_OFF};
    vh = 4'b0000;
    case (mode_ff[3:0])
      4'd0: begin hs = '{MCI_SCALE_HALF, MCI_SCALE_HALF, MCI_SCALE_HALF, MCI_SCALE_HALF}; vh = 4'b1111; end // RULE11
      4'd1: begin hs[0] = MCI_SCALE_FULL; hs[1] = MCI_SCALE_FULL; vh = 4'b0011; end // RULE11
      4'd2: begin hs[0] = MCI_SCALE_FULL; hs[1] = MCI_SCALE_HALF; hs[2] = MCI_SCALE_HALF; vh = 4'b0111; end // RULE12
      4'd3: begin hs = '{MCI_SCALE_HALF, MCI_SCALE_QUARTER, MCI_SCALE_HALF, MCI_SCALE_QUARTER}; vh = 4'b0101; end // RULE12
      4'd4: hs[0] = MCI_SCALE_FULL; // RULE13
      4'd5: begin hs[0] = MCI_SCALE_HALF; hs[1] = MCI_SCALE_HALF; end // RULE13
      4'd8: hs = '{MCI_SCALE_FULL, MCI_SCALE_FULL, MCI_SCALE_FULL, MCI_SCALE_FULL}; // RULE13
      default: vh = 4'b0000;
    endcase
  end

  // four identical paths
  for (genvar p = 0; p < 4; p++)
  begin : g_path
    mci_path u_path (
      .i_clock (i_clock),
      .i_resetn(i_resetn),
      .i_enable(i_enable),
      .i_streams(streams),
      .i_select(select_ff[p*3 +: 3]),
      .i_origin(origin_ff[p]),
      .i_span  (span_ff),
      .i_hscale(hs[p]),
      .i_vhalf (vh[p]),
      .o_status(st[p]),
      .o_data  (o_path_data[p*8 +: 8]),
      .o_valid (o_path_valid[p]),
      .i_ready (i_path_ready[p])
    );
    assign o_path_status[p*4 +: 4] = st[p];
  end
endmodule
`default_nettype wire

// [mci_regs.svh]
// register offsets, reset values and timing counts for the capture paths
`ifndef MCI_REGS_SVH
`define MCI_REGS_SVH
`define MCI_OFF_PART_MODE     8'hA0
`define MCI_OFF_SPAN_LO       8'hA4
`define MCI_OFF_SPAN_HI       8'hA5
`define MCI_OFF_ORIGIN_CH0    8'hC3
`define MCI_OFF_ORIGIN_CH3    8'hC6
`define MCI_OFF_SOURCE_SEL    8'hB0
`define MCI_OFF_STATUS_BASE   8'hB4
`define MCI_RST_PART_MODE     8'h08
`define MCI_RST_SPAN          16'h05A0
`define MCI_RST_ORIGIN        8'h00
`define MCI_RST_SELECT        12'h688
`define MCI_TIMEOUT_MS        2
`define MCI_CLOCK_KHZ         27000
`define MCI_TIMEOUT_CYCLES    (`MCI_TIMEOUT_MS * `MCI_CLOCK_KHZ)
`define MCI_WIDE_SAMPLES      12'd1440
`define MCI_PAL_LINES         10'd312
`define MCI_NTSC_LINES        10'd262
`define MCI_FIFO_DEPTH        8
`endif

// [mci_pkg.sv]
// types shared by the capture path design
`default_nettype none
package mci_pkg;
  typedef enum logic [1:0] {
    MCI_SCALE_FULL    = 2'b00,
    MCI_SCALE_HALF    = 2'b01,
    MCI_SCALE_QUARTER = 2'b10,
    MCI_SCALE_OFF     = 2'b11
  } mci_hscale_t;
  typedef struct packed {
    logic       sav;
    logic       field;
    logic [7:0] data;
  } mci_sample_t;
  typedef struct packed {
    logic no_signal_flag;
    logic wide_source_flag;
    logic pal_lines_flag;
    logic ntsc_lines_flag;
  } mci_status_t;
endpackage
`default_nettype wire

// [mci_capture_checker.sv]
// checker: register and output properties of the capture block
`default_nettype none
// ************
// checker
// ************
module mci_capture_checker (
  input wire logic        i_clock,
  input wire logic        i_resetn,
  input wire logic        i_enable,
  input wire logic        i_reg_write,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic [7:0]  o_reg_rdata,
  input wire logic [31:0] o_path_data,
  input wire logic [3:0]  o_path_valid,
  input wire logic [3:0]  i_path_ready,
  input wire logic [15:0] o_path_status
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // plain storage bytes, read back whole
  wire logic rw_addr = i_reg_addr inside {8'hA0, 8'hA4, 8'hA5, [8'hC3:8'hC6]};
  wire logic mapped  = rw_addr || (i_reg_addr inside {[8'hB0:8'hB1], [8'hB4:8'hB7]});
  a_reset_status: assert property ($rose(i_resetn) |-> o_path_status == 16'h8888)
    else $error("status not at reset value");
  a_reset_mode: assert property ($rose(i_resetn) && i_reg_addr == 8'hA0 |-> o_reg_rdata == 8'h08)
    else $error("partition mode reset value wrong");
  a_write_back: assert property (i_enable && i_reg_write && rw_addr ##1 $stable(i_reg_addr)
    |-> o_reg_rdata == $past(i_reg_wdata)) else $error("written byte not read back");
  a_select_back: assert property (i_enable && i_reg_write && i_reg_addr inside {8'hB0, 8'hB1}
    ##1 $stable(i_reg_addr) |-> o_reg_rdata[5:0] == $past(i_reg_wdata[5:0])) else $error("select readback");
  a_unmapped_zero: assert property (!mapped |-> o_reg_rdata == 8'h00)
    else $error("unmapped address reads nonzero");
  a_frozen_regs: assert property (!i_enable ##1 $stable(i_reg_addr) |-> $stable(o_reg_rdata))
    else $error("register changed while disabled");
  a_status_frozen: assert property (!i_enable |=> $stable(o_path_status))
    else $error("status changed while disabled");
  a_stall_hold: assert property (o_path_valid[0] && !i_path_ready[0]
    |=> o_path_valid[0] && $stable(o_path_data[7:0])) else $error("head moved while stalled");
  // main scenarios reached
  c_write: cover property (i_enable && i_reg_write && rw_addr);
  c_stall: cover property (o_path_valid[0] && !i_path_ready[0] [*4]);
  c_found: cover property ($fell(o_path_status[3]));
endmodule
`default_nettype wire

// [mci_source_model.sv]
// source model: four decoder buses and one line-interleaved tdm bus
`default_nettype none
// ************
// source model
// ************
module mci_source_model #(
  parameter int ACT   = 16,
  parameter int BLANK = 4,
  parameter int FLINES = 8
) (
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  output logic      [31:0] o_decoder_stream,
  output logic      [7:0]  o_tdm_stream
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LEN = ACT + BLANK + 8;
  int         pos_ff;
  logic [1:0] chan_ff;
  int         line_ff;
  logic       fld_ff;
  // one symbol of a line: start code, samples, end code, blanking
  function automatic logic [7:0] sym(int p, logic [7:0] base, logic [7:0] sav, logic [7:0] eav);
    if (p == 0 || p == ACT + 4)
      return 8'hFF;
    if (p < 3 || (p > ACT + 4 && p < ACT + 7))
      return 8'h00;
    if (p == 3)
      return sav;
    if (p == ACT + 7)
      return eav;
    if (p < ACT + 4)
      return base + 8'(p - 4);
    return 8'h10;
  endfunction
  // whole lines per tdm channel so each id owns its samples
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pos_ff <= 0;
      chan_ff <= 2'h0;
      line_ff <= 0;
      fld_ff <= 1'b0;
      o_decoder_stream <= {4{8'h10}};
      o_tdm_stream <= 8'h10;
    end
    else
    begin
      pos_ff <= (pos_ff == LEN - 1) ? 0 : pos_ff + 1;
      if (pos_ff == LEN - 1)
      begin
        chan_ff <= chan_ff + 2'h1;
        line_ff <= (line_ff == FLINES - 1) ? 0 : line_ff + 1;
        // short fields, so the watchdog sees live video soon after reset
        if (line_ff == FLINES - 1)
          fld_ff <= !fld_ff;
      end
      for (int n = 0; n < 4; n++)
        o_decoder_stream[n*8 +: 8] <= sym(pos_ff, 8'h20 + 8'(n * 16), fld_ff ? 8'hC7 : 8'h80,
                                          fld_ff ? 8'hDA : 8'h9D);
      o_tdm_stream <= sym(pos_ff, 8'h80 + 8'(chan_ff) * 8'h10, {1'b1, fld_ff, 4'h0, chan_ff},
                          {1'b1, fld_ff, 4'h4, chan_ff});
    end
  end
endmodule
`default_nettype wire

// [mci_capture_bench.sv]
// testbench for the four-path capture block
`default_nettype none
// ************
// bench top
// ************
module mci_capture_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clock, i_resetn, i_enable, i_reg_write;
  logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, tdm;
  logic [31:0] dec, o_path_data;
  logic [3:0]  o_path_valid, i_path_ready;
  logic [15:0] o_path_status;
  logic [2:0]  sh [4] = '{3'd0, 3'd1, 3'd2, 3'd3};
  int          num_errors, check_count;
  localparam logic [7:0] ADR [10] = '{8'hA0, 8'hA4, 8'hA5, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hB0, 8'hB1, 8'hB8};
  localparam logic [7:0] RST [10] = '{8'h08, 8'hA0, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h1A, 8'h00};
  mci_source_model u_src (.i_clock(i_clock), .i_resetn(i_resetn), .o_decoder_stream(dec), .o_tdm_stream(tdm));
  mci_capture DUT (.i_clock(i_clock), .i_resetn(i_resetn), .i_enable(i_enable), .i_decoder_stream(dec),
    .i_tdm_stream(tdm), .i_reg_write(i_reg_write), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_path_data(o_path_data), .o_path_valid(o_path_valid),
    .i_path_ready(i_path_ready), .o_path_status(o_path_status));
  // 40 MHz clock
  initial
  begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  task automatic check(string nm, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic reg_wr(logic [7:0] a, logic [7:0] d);
    @(negedge i_clock);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_write = 1'b1;
    @(negedge i_clock);
    i_reg_write = 1'b0;
  endtask
  task automatic reg_rd(logic [7:0] a, logic [7:0] e);
    @(negedge i_clock);
    i_reg_addr = a;
    #1 check("rdata", e, o_reg_rdata);
  endtask
  // reset values, write and read back, unmapped place, frozen write
  task automatic t_regs();
    for (int i = 0; i < 10; i++)
      reg_rd(ADR[i], RST[i]);
    for (int i = 0; i < 10; i++)
      reg_wr(ADR[i], (ADR[i] + 8'h11) & 8'h3F);
    for (int i = 0; i < 10; i++)
      reg_rd(ADR[i], i == 9 ? 8'h00 : (ADR[i] + 8'h11) & 8'h3F);
    i_enable = 1'b0;
    reg_wr(8'hA4, 8'h77);
    i_enable = 1'b1;
    reg_rd(8'hA4, 8'h35);
    $display("test regs done");
  endtask
  // configure one path, then judge two whole lines of its output
  task automatic scen(int p, int sel, logic [7:0] org, logic [7:0] span, logic [7:0] mode, int step);
    logic [7:0] v, w, base;
    int         run, seen;
    base = sel < 4 ? 8'h20 + 8'(sel * 16) : 8'h80 + 8'((sel - 4) * 16);
    sh[p] = 3'(sel);
    reg_wr(8'hB0, {2'b00, sh[1], sh[0]});
    reg_wr(8'hB1, {2'b00, sh[3], sh[2]});
    reg_wr(8'hC3 + 8'(p), org);
    reg_wr(8'hA4, span);
    reg_wr(8'hA5, 8'h00);
    reg_wr(8'hA0, mode);
    repeat (300) @(negedge i_clock);
    v = 8'h00;
    run = 0;
    seen = 0;
    for (int n = 0; n < 2000 && seen < 4; n++)
    begin
      @(negedge i_clock);
      w = o_path_data[p*8 +: 8];
      if (o_path_valid[p] === 1'b1 && w !== 8'h10)
      begin
        if (w > v && run > 0)
        begin
          check("step", 8'(step), w - v);
          run++;
        end
        else
        begin
          if (seen > 1)
            check("run", span / 8'(step), 8'(run));
          if (step == 1 && seen > 0)
            check("start", 8'(base + 2 * org), w);
          seen++;
          run = 1;
        end
        v = w;
      end
    end
    check("lines", 8'h04, 8'(seen));
    check("status", 8'h00, {4'h0, o_path_status[p*4 +: 4]});
    $display("test path %0d source %0d mode %0d done", p, sel, mode);
  endtask
  // stall path 0 until its buffer refuses, then drain it
  task automatic t_stall();
    int cnt;
    @(negedge i_clock);
    i_path_ready[0] = 1'b0;
    repeat (200) @(negedge i_clock);
    check("held", 8'h01, {7'h0, o_path_valid[0]});
    i_path_ready[0] = 1'b1;
    cnt = 0;
    while (o_path_valid[0] === 1'b1 && cnt < 50)
    begin
      @(negedge i_clock);
      cnt++;
    end
    check("drained", 8'h01, {7'h0, cnt >= 8});
    $display("test stall done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // watchdog against a hang
  initial
  begin
    repeat (80000) @(posedge i_clock);
    num_errors++;
    $display("watchdog expired");
    tally_and_finish();
  end
  // main sequence
  initial
  begin
    i_resetn = 1'b0;
    i_enable = 1'b1;
    i_reg_write = 1'b0;
    i_reg_addr = 8'hA0;
    i_reg_wdata = 8'h00;
    i_path_ready = 4'hF;
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    i_resetn = 1'b1;
    t_regs();
    for (int s = 0; s < 8; s++)
      scen(s % 4, s, 8'h01, 8'h04, 8'h08, 1);
    scen(0, 0, 8'h02, 8'h08, 8'h00, 2);
    scen(0, 0, 8'h02, 8'h08, 8'h01, 1);
    scen(1, 1, 8'h02, 8'h08, 8'h02, 2);
    scen(0, 0, 8'h01, 8'h04, 8'h04, 1);
    scen(1, 1, 8'h02, 8'h08, 8'h03, 4);
    scen(1, 1, 8'h02, 8'h08, 8'h05, 2);
    t_stall();
    tally_and_finish();
  end
endmodule
bind mci_capture mci_capture_checker u_chk (.i_clock(i_clock), .i_resetn(i_resetn), .i_enable(i_enable),
  .i_reg_write(i_reg_write), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .o_path_data(o_path_data), .o_path_valid(o_path_valid), .i_path_ready(i_path_ready),
  .o_path_status(o_path_status));
`default_nettype wire
